// ===== hw/smp_reg_bank.sv
`timescale 1ns/1ps
module smp_reg_bank
	import smp_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        miso,
	output logic             sclk,
	output logic             mosi,
	output logic      [3:0]  cs_n,
	output logic             irq
);
	typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SHIFT, ST_FINISH} smp_st_t;

	smp_st_t     st_ff;
	logic [7:0]  mem [FIFO_BYTES];
	logic [6:0]  wptr_ff, rptr_ff, fill, free;
	logic [31:0] clk_ff, cmd_ff, cfg_ff;
	logic [13:0] thr_ff;
	logic [4:0]  rpt_ff;
	logic [10:0] interrupt_enable_mask_ff, istat_ff, iset;
	logic [11:0] left_ff;
	logic [7:0]  tx_ff, rx_ff, rx_byte;
	logic [2:0]  bit_ff;
	logic        par_ff, offs_ff, miso_m_ff, miso_ff, edge_pulse;
	logic        req, wr, rd, cmd_go, bus_push, bus_pop, eng_pop, eng_push;
	logic        samp, drive, byte_done, lsb_first, op_read, spi;
	logic [31:0] rdata, wmask;
	logic [6:0]  nxt_wptr, nxt_rptr;
	logic [11:0] cmd_len;
	logic [1:0]  chan;

	assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr    = req && wb_we_i;
	assign rd    = req && !wb_we_i;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign fill  = wptr_ff - rptr_ff;
	assign free  = FIFO_SIZE - fill;
	assign spi   = cfg_ff[CFG_SPI];
	assign lsb_first = cmd_ff[CMD_LSB];
	assign op_read   = cmd_ff[CMD_OPERATION_CODE + OP_READ];
	assign chan      = cmd_ff[CMD_SLAVE_CHANNEL +: 2];
	// spi length takes the upper bits, i2c keeps the byte field only
	assign cmd_len = spi ? {wb_dat_i[CMD_UPL +: 4], wb_dat_i[7:0]}
		: {4'h0, wb_dat_i[7:0]};

	// bus side: a FIFO word is refused while the master is disabled
	assign bus_push = wr && wb_adr_i == ADR_FIFO && cfg_ff[CFG_EN]
		&& free >= 7'h04;
	assign bus_pop  = rd && wb_adr_i == ADR_FIFO && cfg_ff[CFG_EN]
		&& fill >= 7'h04;
	assign cmd_go   = wr && wb_adr_i == ADR_CMD && cfg_ff[CFG_EN]
		&& st_ff == ST_IDLE && !wb_dat_i[CMD_OPERATION_CODE + OP_BAD];

	// miso is a pin and passes two flops before the shifter reads it
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			miso_m_ff <= 1'b0;
			miso_ff   <= 1'b0;
		end else begin
			miso_m_ff <= miso;
			miso_ff   <= miso_m_ff;
		end
	end

	smp_clk_gen u_clk (
		.ref_clk    (ref_clk),
		.sys_rst    (sys_rst),
		.run        (st_ff == ST_SHIFT),
		.src_sel    (clk_ff[CK_SOURCE_CLOCK_SELECT +: 3]),
		.divide_by_three_en    (clk_ff[CK_DIVIDE_BY_THREE]),
		.per_en     (clk_ff[CK_PERIOD_DIVIDE_ENABLE]),
		.per_m1     (clk_ff[CK_PER +: 8]),
		.low_m1     (clk_ff[CK_LOW +: 8]),
		.edge_pulse (edge_pulse)
	);

	// par_ff is zero before the first edge of each bit
	assign samp  = edge_pulse && st_ff == ST_SHIFT
		&& (par_ff == cfg_ff[CFG_PHA]);
	assign drive = edge_pulse && st_ff == ST_SHIFT && !samp;
	assign byte_done = samp && bit_ff == 3'h7;
	assign eng_pop  = st_ff == ST_LOAD && !offs_ff && !op_read
		&& fill != 7'h00;
	assign eng_push = byte_done && !offs_ff && op_read && free != 7'h00;
	// the FIFO takes the byte with its last bit, not the stale shifter
	assign rx_byte  = lsb_first ? {miso_ff, rx_ff[7:1]}
		: {rx_ff[6:0], miso_ff};

	// register writes, byte lanes honoured for CLK and CFG only
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			clk_ff   <= RST_WORD;
			cfg_ff   <= RST_WORD;
			thr_ff   <= 14'h0000;
			interrupt_enable_mask_ff <= 11'h000;
		end else if (wr) begin
			case (wb_adr_i)
				ADR_CLK:   clk_ff <= (clk_ff & ~wmask)
					| (wb_dat_i & wmask & 32'hFFFF_1F00);
				ADR_CFG:   cfg_ff <= (cfg_ff & ~wmask)
					| (wb_dat_i & wmask & 32'h8000_0007);
				ADR_THR:   thr_ff <= wb_dat_i[13:0] & 14'h3F3F;
				ADR_INTERRUPT_ENABLE_MASK: interrupt_enable_mask_ff <= wb_dat_i[10:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			cmd_ff <= RST_WORD;
		else if (cmd_go)
			cmd_ff <= wb_dat_i;
	end

	// repeat count: software loads it, each rerun uses one up
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			rpt_ff <= 5'h00;
		else if (wr && wb_adr_i == ADR_RPT)
			rpt_ff <= wb_dat_i[4:0];
		else if (st_ff == ST_FINISH && rpt_ff != 5'h00)
			rpt_ff <= rpt_ff - 5'h01;
	end

	// FIFO storage and pointers, shared by bus and engine
	always_comb begin
		nxt_wptr = wptr_ff + (bus_push ? 7'h04 : 7'h00)
			+ {6'h00, eng_push};
		nxt_rptr = rptr_ff + (bus_pop ? 7'h04 : 7'h00)
			+ {6'h00, eng_pop};
	end

	always_ff @(posedge ref_clk) begin
		if (bus_push)
			for (int i = 0; i < 4; i++)
				mem[6'(wptr_ff + 7'(i))] <= wb_dat_i[8*i +: 8];
		if (eng_push)
			mem[6'(bus_push ? wptr_ff + 7'h04 : wptr_ff)] <= rx_byte;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || !cfg_ff[CFG_EN]) begin
			wptr_ff <= 7'h00;
			rptr_ff <= 7'h00;
		end else begin
			wptr_ff <= nxt_wptr;
			rptr_ff <= nxt_rptr;
		end
	end

	// transfer engine
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !cfg_ff[CFG_EN]) begin
			st_ff <= ST_IDLE;
		end else begin
			case (st_ff)
				ST_IDLE:   if (cmd_go) st_ff <= ST_LOAD;
				ST_LOAD:   if (!offs_ff && left_ff == 12'h000)
						st_ff <= ST_FINISH;
					else if (!offs_ff && !op_read && fill == 7'h00)
						st_ff <= ST_FINISH;
					else
						st_ff <= ST_SHIFT;
				ST_SHIFT:  if (byte_done)
						st_ff <= (!offs_ff && left_ff == 12'h001)
							? ST_FINISH : ST_LOAD;
				ST_FINISH: st_ff <= (rpt_ff != 5'h00) ? ST_LOAD : ST_IDLE;
				default:   st_ff <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			left_ff <= 12'h000;
			offs_ff <= 1'b0;
		end else if (cmd_go) begin
			left_ff <= cmd_len;
			offs_ff <= !wb_dat_i[CMD_OPERATION_CODE + OP_RAW];
		end else if (st_ff == ST_FINISH && rpt_ff != 5'h00) begin
			left_ff <= spi ? {cmd_ff[CMD_UPL +: 4], cmd_ff[7:0]}
				: {4'h0, cmd_ff[7:0]};
			offs_ff <= !cmd_ff[CMD_OPERATION_CODE + OP_RAW];
		end else if (byte_done) begin
			if (offs_ff)
				offs_ff <= 1'b0;
			else
				left_ff <= left_ff - 12'h001;
		end
	end

	// shifter: load a byte, shift it out, gather the reply
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_ff  <= TX_IDLE_BYTE;
			rx_ff  <= 8'h00;
			bit_ff <= 3'h0;
			par_ff <= 1'b0;
		end else if (st_ff == ST_LOAD) begin
			tx_ff  <= offs_ff ? cmd_ff[CMD_OFFS +: 8]
				: (op_read ? TX_IDLE_BYTE : mem[6'(rptr_ff)]);
			bit_ff <= 3'h0;
			par_ff <= 1'b0;
		end else if (edge_pulse && st_ff == ST_SHIFT) begin
			par_ff <= !par_ff;
			if (samp) begin
				bit_ff <= bit_ff + 3'h1;
				rx_ff  <= rx_byte;
			end
			// sample-late mode: the leading edge only presents the first bit
			if (drive && bit_ff != 3'h0)
				tx_ff <= lsb_first ? {1'b1, tx_ff[7:1]}
					: {tx_ff[6:0], 1'b1};
		end
	end

	// pins; the clock rests at the programmed idle level
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sclk <= 1'b0;
			mosi <= 1'b1;
		end else begin
			if (st_ff != ST_SHIFT)
				sclk <= cfg_ff[CFG_POL];
			else if (edge_pulse)
				sclk <= !sclk;
			mosi <= lsb_first ? tx_ff[0] : tx_ff[7];
		end
	end

	// chip select only in SPI mode; a held command leaves it low
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !cfg_ff[CFG_EN]) begin
			cs_n <= 4'hF;
		end else if (st_ff == ST_LOAD && spi) begin
			cs_n <= ~(4'h1 << chan);
		end else if (st_ff == ST_FINISH && rpt_ff == 5'h00
			&& !cmd_ff[CMD_HOLD]) begin
			cs_n <= 4'hF;
		end
	end

	// interrupt events
	always_comb begin
		iset = 11'h000;
		iset[IQ_DONE]  = st_ff == ST_FINISH;
		iset[IQ_THR]   = (eng_push && fill == {1'b0, thr_ff[5:0]})
			|| (eng_pop && fill == {1'b0, thr_ff[13:8]} + 7'h01);
		iset[IQ_UND]   = st_ff == ST_LOAD && !offs_ff && !op_read
			&& left_ff != 12'h000 && fill == 7'h00;
		iset[IQ_OVF]   = byte_done && !offs_ff && op_read
			&& free == 7'h00;
		iset[IQ_WLEN]  = st_ff == ST_FINISH && !op_read && rpt_ff == 5'h00
			&& fill != 7'h00;
		iset[IQ_BAD_FIFO_ACCESS_IRQ]  = req && wb_adr_i == ADR_FIFO
			&& !bus_push && !bus_pop;
		iset[IQ_BAD_COMMAND_IRQ]  = wr && wb_adr_i == ADR_CMD && !cmd_go;
		iset[IQ_START] = cmd_go && !spi;
		iset[IQ_STOP]  = st_ff == ST_FINISH && !spi && rpt_ff == 5'h00
			&& !cmd_ff[CMD_HOLD];
	end

	// an event landing on its own clear stays pending
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			istat_ff <= 11'h000;
		else if (wr && wb_adr_i == ADR_INTERRUPT_CLEAR_REGISTER)
			istat_ff <= (istat_ff & ~wb_dat_i[10:0]) | iset;
		else
			istat_ff <= istat_ff | iset;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			irq <= 1'b0;
		else
			irq <= |(istat_ff & interrupt_enable_mask_ff);
	end

	// read mux; unmapped words read zero
	always_comb begin
		case (wb_adr_i)
			ADR_FIFO:  rdata = bus_pop ? {mem[6'(rptr_ff + 7'h03)],
				mem[6'(rptr_ff + 7'h02)], mem[6'(rptr_ff + 7'h01)],
				mem[6'(rptr_ff)]} : RST_WORD;
			ADR_PTR:   rdata = {9'h000, free, 9'h000, fill};
			ADR_LEFT:  rdata = {20'h0_0000, left_ff};
			ADR_THR:   rdata = {18'h0_0000, thr_ff};
			ADR_CLK:   rdata = clk_ff;
			ADR_CMD:   rdata = cmd_ff;
			ADR_RPT:   rdata = {27'h000_0000, rpt_ff};
			ADR_STAT:  rdata = {29'h0000_0000, st_ff == ST_IDLE,
				st_ff != ST_IDLE,
				|(istat_ff & IQ_ERR_MASK)};
			ADR_CFG:   rdata = cfg_ff;
			ADR_INTERRUPT_ENABLE_MASK: rdata = {21'h00_0000, interrupt_enable_mask_ff};
			ADR_INTERRUPT_STATUS_REGISTER: rdata = {21'h00_0000, istat_ff};
			default:   rdata = RST_WORD;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= RST_WORD;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= rd ? rdata : RST_WORD;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence s_cmd_issue;
		cmd_go;
	endsequence
	sequence s_engine_busy;
		st_ff != ST_IDLE ##1 st_ff != ST_IDLE;
	endsequence

	property p_ack_single;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_single: assert property (p_ack_single)
		else $error("ack held longer than one cycle");
	property p_busy;
		s_cmd_issue |=> s_engine_busy;
	endproperty
	a_busy: assert property (p_busy)
		else $error("engine not busy after command");
	property p_free;
		wb_ack_o && $past(wb_adr_i) == ADR_PTR && !$past(wb_we_i)
			|-> wb_dat_o[22:16] + wb_dat_o[6:0] == FIFO_SIZE;
	endproperty
	a_free: assert property (p_free)
		else $error("free plus fill is not the FIFO size");
	property p_refuse;
		req && wb_adr_i == ADR_FIFO && !cfg_ff[CFG_EN]
			|=> istat_ff[IQ_BAD_FIFO_ACCESS_IRQ] && wptr_ff == 7'h00;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("FIFO access taken while disabled");
	property p_disable;
		!cfg_ff[CFG_EN] |=> st_ff == ST_IDLE && cs_n == 4'hF;
	endproperty
	a_disable: assert property (p_disable)
		else $error("engine ran while disabled");
	property p_left;
		byte_done && !offs_ff |=> left_ff == $past(left_ff) - 12'h001;
	endproperty
	a_left: assert property (p_left)
		else $error("length did not count down");
	property p_hold;
		st_ff == ST_FINISH && spi && cmd_ff[CMD_HOLD] && cfg_ff[CFG_EN]
			|=> cs_n[chan] == 1'b0;
	endproperty
	a_hold: assert property (p_hold)
		else $error("chip select released on held command");
	property p_idle_clk;
		st_ff == ST_IDLE ##1 st_ff == ST_IDLE |-> sclk == $past(cfg_ff[1]);
	endproperty
	a_idle_clk: assert property (p_idle_clk)
		else $error("serial clock not at idle level");
	property p_irq_gate;
		(istat_ff & interrupt_enable_mask_ff) == 11'h000 |=> !irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt without enabled source");
	property p_irq_set;
		(istat_ff & interrupt_enable_mask_ff) != 11'h000 |=> irq;
	endproperty
	a_irq_set: assert property (p_irq_set)
		else $error("enabled source did not raise interrupt");
endmodule : smp_reg_bank

// ===== inc/smp_pkg.sv
package smp_pkg;
	localparam logic [9:0] ADR_FIFO    = 10'h000;
	localparam logic [9:0] ADR_PTR     = 10'h100;
	localparam logic [9:0] ADR_LEFT    = 10'h104;
	localparam logic [9:0] ADR_THR     = 10'h108;
	localparam logic [9:0] ADR_CLK     = 10'h10C;
	localparam logic [9:0] ADR_CMD     = 10'h110;
	localparam logic [9:0] ADR_RPT     = 10'h114;
	localparam logic [9:0] ADR_STAT    = 10'h118;
	localparam logic [9:0] ADR_CFG     = 10'h11C;
	localparam logic [9:0] ADR_INTERRUPT_ENABLE_MASK   = 10'h200;
	localparam logic [9:0] ADR_INTERRUPT_STATUS_REGISTER = 10'h204;
	localparam logic [9:0] ADR_INTERRUPT_CLEAR_REGISTER  = 10'h208;
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;
	localparam int FIFO_BYTES = 64;
	localparam logic [6:0] FIFO_SIZE = 7'h40;
	localparam int CFG_EN   = 31;
	localparam int CFG_PHA  = 2;
	localparam int CFG_POL  = 1;
	localparam int CFG_SPI  = 0;
	localparam int CK_PER   = 24;
	localparam int CK_LOW   = 16;
	localparam int CK_PERIOD_DIVIDE_ENABLE = 12;
	localparam int CK_DIVIDE_BY_THREE  = 11;
	localparam int CK_SOURCE_CLOCK_SELECT  = 8;
	localparam int CMD_OFFS = 8;
	localparam int CMD_ADDR = 16;
	localparam int CMD_SLAVE_CHANNEL = 16;
	localparam int CMD_UPL  = 23;
	localparam int CMD_10B  = 26;
	localparam int CMD_LSB  = 27;
	localparam int CMD_HOLD = 28;
	localparam int CMD_OPERATION_CODE = 29;
	localparam int WTHR_POS = 8;
	localparam int IRQ_N    = 11;
	localparam int IQ_DONE  = 0;
	localparam int IQ_THR   = 1;
	localparam int IQ_UND   = 2;
	localparam int IQ_OVF   = 3;
	localparam int IQ_NAK   = 4;
	localparam int IQ_WLEN  = 5;
	localparam int IQ_BAD_FIFO_ACCESS_IRQ  = 6;
	localparam int IQ_BAD_COMMAND_IRQ  = 7;
	localparam int IQ_START = 8;
	localparam int IQ_STOP  = 9;
	localparam int IQ_ARB   = 10;
	localparam logic [10:0] IQ_ERR_MASK = 11'h4FC;
	localparam logic [7:0] TX_IDLE_BYTE = 8'hFF;
	// operation code: bit0 read, bit1 raw (no offset byte), bit2 illegal
	localparam int OP_READ = 0;
	localparam int OP_RAW  = 1;
	localparam int OP_BAD  = 2;
endpackage : smp_pkg

// ===== hw/smp_clk_gen.sv
`timescale 1ns/1ps
module smp_clk_gen
	import smp_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       run,
	input  wire logic [2:0] src_sel,
	input  wire logic       divide_by_three_en,
	input  wire logic       per_en,
	input  wire logic [7:0] per_m1,
	input  wire logic [7:0] low_m1,
	output logic            edge_pulse
);
	logic [5:0] pre_ff;
	logic [5:0] src_mask;
	logic       src_tick;
	logic [1:0] d3_ff;
	logic       mid_tick;
	logic [7:0] per_ff;

	always_comb begin
		case (src_sel)
			3'h0: src_mask = 6'h3F;
			3'h1: src_mask = 6'h00;
			3'h2: src_mask = 6'h01;
			3'h3: src_mask = 6'h03;
			3'h4: src_mask = 6'h07;
			3'h5: src_mask = 6'h0F;
			3'h6: src_mask = 6'h1F;
			default: src_mask = 6'h3F;
		endcase
	end
	// the reserved select code yields no ticks at all
	assign src_tick = (src_sel != 3'h7) && ((pre_ff & src_mask) == src_mask);
	assign mid_tick = src_tick && (!divide_by_three_en || d3_ff == 2'h2);

	always_ff @(posedge ref_clk) begin
		if (sys_rst || !run)
			pre_ff <= 6'h00;
		else
			pre_ff <= pre_ff + 6'h01;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || !run)
			d3_ff <= 2'h0;
		else if (src_tick)
			d3_ff <= (d3_ff == 2'h2) ? 2'h0 : d3_ff + 2'h1;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || !run)
			per_ff <= 8'h00;
		else if (mid_tick)
			per_ff <= (per_ff >= per_m1) ? 8'h00 : per_ff + 8'h01;
	end

	// edges at the end of the low phase and at the wrap of the period
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !run)
			edge_pulse <= 1'b0;
		else if (!per_en)
			edge_pulse <= mid_tick;
		else
			edge_pulse <= mid_tick && (per_ff == low_m1
				|| per_ff >= per_m1);
	end
endmodule : smp_clk_gen

// ===== verif/smp_spi_slave.sv
`timescale 1ns/1ps
module smp_spi_slave (
	input  wire logic       sclk,
	input  wire logic       mosi,
	input  wire logic       sel_n,
	output logic            miso,
	output logic      [7:0] rx_last,
	output int              rx_cnt
);
	// mode 0 peripheral: answers byte k of the run with 3C + 11*k
	logic [7:0] tx_sr;
	logic [7:0] rx_sr;
	logic [7:0] tx_nxt;
	int         bit_n;
	initial begin
		miso = 1'b0;
		tx_sr = 8'h00;
		rx_sr = 8'h00;
		tx_nxt = 8'h3C;
		bit_n = 0;
		rx_cnt = 0;
		rx_last = 8'h00;
	end
	always @(negedge sel_n) begin
		tx_sr = tx_nxt;
		miso = tx_nxt[7];
		bit_n = 0;
	end
	// released line: flip so a stale bit never looks valid
	always @(posedge sel_n) miso = ~miso;
	always @(posedge sclk) begin
		if (!sel_n) begin
			rx_sr = {rx_sr[6:0], mosi};
			bit_n++;
			if (bit_n == 8) begin
				rx_last = rx_sr;
				rx_cnt++;
				bit_n = 0;
				tx_nxt = tx_nxt + 8'h11;
			end
		end
	end
	always @(negedge sclk) begin
		if (!sel_n) begin
			tx_sr = (bit_n == 0) ? tx_nxt : {tx_sr[6:0], 1'b0};
			miso = tx_sr[7];
		end
	end
endmodule : smp_spi_slave

// ===== verif/test_serial_master_register_bank.sv
`timescale 1ns/1ps
module test_serial_master_register_bank;
	import smp_pkg::*;
	logic        ref_clk;
	logic        sys_rst;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [9:0]  adr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic        miso;
	logic        sclk;
	logic        mosi;
	logic [3:0]  cs_n;
	logic        irq;
	logic [7:0]  rx_last;
	int          rx_cnt;
	int          n_mismatch;
	int          samples_checked;
	localparam logic [9:0] RA [7] = '{ADR_THR, ADR_CLK, ADR_RPT, ADR_CFG,
		ADR_INTERRUPT_ENABLE_MASK, ADR_LEFT, 10'h3FC};
	localparam logic [31:0] RM [7] = '{32'h0000_3F3F, 32'hFFFF_1F00,
		32'h0000_001F, 32'h8000_0007, 32'h0000_07FF, 32'h0, 32'h0};

	smp_reg_bank dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .miso(miso),
		.sclk(sclk), .mosi(mosi), .cs_n(cs_n), .irq(irq));
	smp_spi_slave peer (.sclk(sclk), .mosi(mosi), .sel_n(cs_n[0]),
		.miso(miso), .rx_last(rx_last), .rx_cnt(rx_cnt));

	always #2 ref_clk = ~ref_clk;

	task automatic tally_and_finish;
		$display("compared %0d mismatched %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one classic cycle; read data is taken at the edge that sees ack
	task automatic wb(input logic [9:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge ref_clk);
		while (ack !== 1'b1 && n < 50) begin
			@(posedge ref_clk);
			n++;
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50) begin
			n_mismatch++;
			tally_and_finish();
		end
		@(posedge ref_clk);
	endtask : wb

	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(a, 1'b1, d, q);
	endtask : wr

	task automatic rd(input logic [9:0] a, output logic [31:0] q);
		wb(a, 1'b0, 32'h0, q);
	endtask : rd

	task automatic wait_idle;
		logic [31:0] s;
		for (int i = 0; i < 600; i++) begin
			rd(ADR_STAT, s);
			if (s[1] === 1'b0) return;
		end
		n_mismatch++;
		tally_and_finish();
	endtask : wait_idle

	// high and low time of one serial clock period, in ref_clk cycles
	task automatic meas(output int hi, output int lo);
		int n;
		n = 0;
		hi = 0;
		lo = 0;
		while (sclk !== 1'b1 && n < 3000) begin
			@(posedge ref_clk);
			n++;
		end
		while (sclk === 1'b1 && n < 3000) begin
			@(posedge ref_clk);
			n++;
			hi++;
		end
		while (sclk !== 1'b1 && n < 3000) begin
			@(posedge ref_clk);
			n++;
			lo++;
		end
		if (n >= 3000) begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask : meas

	initial begin
		logic [31:0] q;
		logic [31:0] e;
		int          k0;
		int          hi;
		int          lo;
		int          eh;
		int          el;
		ref_clk = 1'b0;
		sys_rst = 1'b1;
		{cyc, stb, we} = 3'b000;
		adr = 10'h000;
		wdat = 32'h0;
		n_mismatch = 0;
		samples_checked = 0;
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		rd(ADR_PTR, q); chk("ptr_rst", 32'h0040_0000, q);
		rd(ADR_STAT, q); chk("stat_rst", 32'h0000_0004, q);
		for (int i = 0; i < 7; i++) begin
			rd(RA[i], q); chk("reg_rst", 32'h0, q);
			wr(RA[i], 32'hFFFF_FFFF);
			rd(RA[i], q); chk("reg_ones", RM[i], q);
			wr(RA[i], 32'h0);
		end
		rd(ADR_INTERRUPT_STATUS_REGISTER, q); chk("ist_quiet", 32'h0, q);
		// fifo push while disabled is refused and flagged
		wr(ADR_FIFO, 32'h1234_5678);
		rd(ADR_PTR, q); chk("ptr_dis", 32'h0040_0000, q);
		rd(ADR_INTERRUPT_STATUS_REGISTER, q); chk("ist_acc", 32'h0000_0040, q);
		rd(ADR_STAT, q); chk("stat_err", 32'h0000_0005, q);
		chk("irq_mask", 32'h0, irq);
		wr(ADR_INTERRUPT_ENABLE_MASK, 32'h0000_0040);
		chk("irq_on", 32'h1, irq);
		wr(ADR_INTERRUPT_CLEAR_REGISTER, 32'h0000_0040);
		rd(ADR_INTERRUPT_STATUS_REGISTER, q); chk("ist_clr", 32'h0, q);
		chk("irq_off", 32'h0, irq);
		wr(ADR_CFG, 32'h0000_0002);
		chk("idle_hi", 32'h1, sclk);
		wr(ADR_CFG, 32'h8000_0001);
		chk("idle_lo", 32'h0, sclk);
		// two sync flops on the input: receive needs half periods of 3+
		wr(ADR_CLK, 32'h0000_0300);
		wr(ADR_THR, 32'h0000_0400);
		wr(ADR_FIFO, 32'h0403_0201);
		wr(ADR_FIFO, 32'h8143_C2A5);
		rd(ADR_PTR, q); chk("ptr8", 32'h0038_0008, q);
		k0 = rx_cnt;
		wr(ADR_CMD, 32'h4000_0008);
		rd(ADR_STAT, q); chk("stat_busy", 32'h0000_0002, q);
		chk("cs_sel", 32'hE, cs_n);
		wait_idle();
		chk("rx_n", k0 + 8, rx_cnt);
		chk("rx_msb", 32'h81, rx_last);
		rd(ADR_STAT, q); chk("stat_idle", 32'h0000_0004, q);
		rd(ADR_LEFT, q); chk("left0", 32'h0, q);
		rd(ADR_INTERRUPT_STATUS_REGISTER, q); chk("ist_done", 32'h0000_0003, q);
		chk("cs_free", 32'hF, cs_n);
		wr(ADR_INTERRUPT_CLEAR_REGISTER, 32'h0000_07FF);
		wr(ADR_FIFO, 32'hB100_0000);
		wr(ADR_CMD, 32'h5800_0004);
		wait_idle();
		chk("rx_lsb", 32'h8D, rx_last);
		chk("cs_hold", 32'hE, cs_n);
		k0 = rx_cnt;
		wr(ADR_CMD, 32'h6000_0004);
		wait_idle();
		chk("cs_rel", 32'hF, cs_n);
		for (int i = 0; i < 4; i++) e[8*i +: 8] = 8'(60 + 17 * (k0 + i));
		rd(ADR_FIFO, q); chk("rx_word", e, q);
		wr(ADR_INTERRUPT_CLEAR_REGISTER, 32'h0000_07FF);
		wr(ADR_CMD, 32'h8000_0001);
		rd(ADR_INTERRUPT_STATUS_REGISTER, q); chk("ist_bad_command_irq", 32'h0000_0080, q);
		wr(ADR_INTERRUPT_CLEAR_REGISTER, 32'h0000_07FF);
		wr(ADR_CMD, 32'h4000_0004);
		wait_idle();
		rd(ADR_INTERRUPT_STATUS_REGISTER, q); chk("ist_und", 32'h04, q & 32'h84);
		rd(ADR_STAT, q); chk("stat_und", 32'h1, q & 32'h1);
		wr(ADR_CFG, 32'h0000_0001);
		wr(ADR_INTERRUPT_CLEAR_REGISTER, 32'h0000_07FF);
		k0 = rx_cnt;
		wr(ADR_CMD, 32'h4000_0001);
		rd(ADR_INTERRUPT_STATUS_REGISTER, q); chk("ist_off", 32'h0000_0080, q);
		chk("rx_off", k0, rx_cnt);
		wr(ADR_CFG, 32'h8000_0001);
		wr(ADR_RPT, 32'h0000_0001);
		wr(ADR_FIFO, 32'h0000_0000);
		wr(ADR_CMD, 32'h4000_0001);
		wait_idle();
		chk("rx_rpt", k0 + 2, rx_cnt);
		rd(ADR_PTR, q); chk("ptr_rpt", 32'h003E_0002, q);
		wr(ADR_RPT, 32'h0);
		wr(ADR_CMD, 32'h6002_0001);
		chk("cs_ch2", 32'hB, cs_n);
		wait_idle();
		// mode 3: the model samples on rising and drives on falling edges
		wr(ADR_CFG, 32'h0000_0007);
		wr(ADR_CFG, 32'h8000_0007);
		wr(ADR_CMD, 32'h0000_A700);
		wait_idle();
		chk("rx_offs", 32'hA7, rx_last);
		wr(ADR_FIFO, 32'hC500_0000);
		wr(ADR_CMD, 32'h4000_0004);
		wait_idle();
		chk("rx_pha", 32'hC5, rx_last);
		k0 = rx_cnt;
		wr(ADR_CMD, 32'h6000_0004);
		wait_idle();
		for (int i = 0; i < 4; i++) e[8*i +: 8] = 8'(60 + 17 * (k0 + i));
		rd(ADR_FIFO, q); chk("rx_pha_rd", e, q);
		wr(ADR_CFG, 32'h0000_0001);
		wr(ADR_CFG, 32'h8000_0001);
		for (int f = 0; f < 8; f++) begin
			eh = (f == 0) ? 64 : (f == 1) ? 1 : (1 << (f - 1));
			el = eh;
			q = {21'h0, 3'(f), 8'h00};
			if (f == 7) begin
				q = 32'h0300_1900;
				eh = 9;
				el = 3;
			end
			wr(ADR_CLK, q);
			wr(ADR_CMD, 32'h6000_0001);
			meas(hi, lo);
			chk("sclk_hi", eh, hi);
			chk("sclk_lo", el, lo);
			wait_idle();
		end
		tally_and_finish();
	end
endmodule : test_serial_master_register_bank
